// *** hw/cps_sequencer.sv ***
`timescale 1ns/1ps
// Overview of operation
// [RULE1] all analog selects low selects sampled checking
// [RULE2] checks enabled 2ms of every 125ms
// [RULE3] over-current checking never gated by sampler
// [RULE4] monitor mode makes voltage checks continuous
// [RULE5] over-charge past delay turns charge off
// [RULE6] over-charge entry leaves discharge untouched
// [RULE7] delay starts at crossing, rechecked at expiry
// [RULE8] charge bit stored, shown after protection ends
// [RULE9] discharge bit may change during over-charge
// [RULE10] release below threshold restores charge on
// [RULE11] two-bit over-charge threshold from config
// [RULE12] over-charge delay default 1.0s equivalent
// [RULE13] under-voltage past delay: discharge off, sleep
// [RULE14] two-bit over-discharge threshold from config
// [RULE15] wake, charge on, release delay, then discharge
// [RULE16] over-discharge 1.0s detect, 7ms release
// [RULE17] charge bit held back during over-charge, both bits during over-discharge
// [RULE18] delays are programmable cycle counts
module cps_sequencer #(
  parameter int unsigned NCELL = cps_pkg::NCELL,
  parameter int unsigned SAMPLE_ON_CYC = cps_pkg::SAMPLE_ON_CYC,
  parameter int unsigned SAMPLE_PERIOD_CYC = cps_pkg::SAMPLE_PERIOD_CYC,
  parameter logic [31:0] OV_DET_CYC = cps_pkg::OV_DET_CYC,
  parameter logic [31:0] UV_DET_CYC = cps_pkg::UV_DET_CYC,
  parameter logic [31:0] UV_REL_CYC = cps_pkg::UV_REL_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic analog_select_bit2_i,
  input wire logic analog_select_bit1_i,
  input wire logic analog_select_bit0_i,
  input wire logic [NCELL-1:0] cell_over_i,
  input wire logic [NCELL-1:0] cell_ovr_below_i,
  input wire logic [NCELL-1:0] cell_under_i,
  input wire logic [NCELL-1:0] cell_uvr_above_i,
  input wire logic over_current_i,
  input wire logic wake_i,
  input wire logic config_write_cmd_i,
  input wire cps_pkg::cps_cfg_s cfg_i,
  input wire logic ctrl_write_i,
  input wire cps_pkg::cps_ctrl_s ctrl_i,
  input wire logic [31:0] ov_det_cyc_i,
  input wire logic [31:0] uv_det_cyc_i,
  input wire logic [31:0] uv_rel_cyc_i,
  input wire logic use_prog_dly_i,
  output cps_pkg::cps_cfg_s cfg_o,
  output logic sample_en_o,
  output logic oc_check_en_o,
  output logic charge_switch_ctrl_o,
  output logic discharge_switch_ctrl_o,
  output logic ov_prot_o,
  output logic uv_prot_o,
  output logic sleep_o
);
  localparam int unsigned PW = $clog2(SAMPLE_PERIOD_CYC + 1);

  cps_pkg::cps_state_e st_q, st_d;
  cps_pkg::cps_cfg_s cfg_q;
  cps_pkg::cps_ctrl_s bits_q;
  logic [PW-1:0] per_q;
  logic chg_q, dis_q;
  logic rel_ok_q;
  logic chg_d, dis_d, rel_ok_d;

  function automatic logic any_set(input logic [NCELL-1:0] v);
    any_set = |v;
  endfunction

  // sample window: first SAMPLE_ON_CYC counts of each period
  logic normal_sel, check_en, per_wrap;
  assign normal_sel = !analog_select_bit2_i && !analog_select_bit1_i &&
                      !analog_select_bit0_i; // RULE1
  assign per_wrap = (per_q == PW'(SAMPLE_PERIOD_CYC - 1));
  assign sample_en_o = per_q < PW'(SAMPLE_ON_CYC); // RULE2
  assign check_en = normal_sel ? sample_en_o : 1'b1; // RULE4
  assign oc_check_en_o = 1'b1; // RULE3

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) per_q <= '0;
    else per_q <= per_wrap ? '0 : per_q + PW'(1);
  end

  // config fields latched on the config write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) cfg_q <= '0;
    else if (config_write_cmd_i) cfg_q <= cfg_i; // RULE11 RULE14
  end
  assign cfg_o = cfg_q;

  // control bits always stored; outputs decide when they show
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) bits_q <= '{charge_bit: 1'b1, discharge_bit: 1'b1};
    else if (ctrl_write_i) bits_q <= ctrl_i; // RULE8 RULE17
  end

  // stored bits mapped to pin levels; polarity lives in one place
  logic chg_bit_lvl, dis_bit_lvl;
  assign chg_bit_lvl = bits_q.charge_bit ? cps_pkg::SW_ON : cps_pkg::SW_OFF;
  assign dis_bit_lvl = bits_q.discharge_bit ? cps_pkg::SW_ON : cps_pkg::SW_OFF;

  // delay loads: programmable or default capacitor equivalents
  logic [31:0] ov_ld, uv_ld, rel_ld;
  assign ov_ld = use_prog_dly_i ? ov_det_cyc_i : OV_DET_CYC; // RULE18 RULE12
  assign uv_ld = use_prog_dly_i ? uv_det_cyc_i : UV_DET_CYC; // RULE16
  assign rel_ld = use_prog_dly_i ? uv_rel_cyc_i : UV_REL_CYC; // RULE16

  // over and under comparator results only start a delay inside the check window; release is not gated
  logic ov_seen, uv_seen, ov_done, uv_done, rel_done;
  logic ov_run, uv_run, rel_run;
  assign ov_seen = check_en && any_set(cell_over_i);
  assign uv_seen = check_en && any_set(cell_under_i);
  // timers keep running across closed windows; the result is rechecked
  assign ov_run = (st_q == cps_pkg::ST_OV_WAIT); // RULE7
  assign uv_run = (st_q == cps_pkg::ST_UV_WAIT);
  assign rel_run = (st_q == cps_pkg::ST_UV_SLEEP) && !sleep_o &&
                   chg_q == cps_pkg::SW_ON && &cell_uvr_above_i && !rel_ok_q;

  cps_delay_timer #(.W(32)) u_ov_tmr (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(ov_run), .load_i(ov_ld),
    .done_o(ov_done)
  );
  cps_delay_timer #(.W(32)) u_uv_tmr (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(uv_run), .load_i(uv_ld),
    .done_o(uv_done)
  );
  cps_delay_timer #(.W(32)) u_rel_tmr (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(rel_run), .load_i(rel_ld),
    .done_o(rel_done)
  );

  // expiry recheck ignores the sample gate so a closed window cannot
  // silently drop a real over-voltage
  logic ov_still, uv_still;
  assign ov_still = any_set(cell_over_i);
  assign uv_still = any_set(cell_under_i);

  // sequencer state
  always_comb begin
    st_d = st_q;
    case (st_q)
      cps_pkg::ST_NORMAL: begin
        if (uv_seen) st_d = cps_pkg::ST_UV_WAIT; // RULE13
        else if (ov_seen) st_d = cps_pkg::ST_OV_WAIT; // RULE7
      end
      cps_pkg::ST_OV_WAIT: begin
        if (ov_done) begin
          st_d = ov_still ? cps_pkg::ST_OV_PROT : cps_pkg::ST_NORMAL; // RULE7
        end
      end
      cps_pkg::ST_OV_PROT: begin
        if (&cell_ovr_below_i) st_d = cps_pkg::ST_NORMAL; // RULE10
      end
      cps_pkg::ST_UV_WAIT: begin
        if (uv_done) begin
          st_d = uv_still ? cps_pkg::ST_UV_SLEEP : cps_pkg::ST_NORMAL;
        end
      end
      cps_pkg::ST_UV_SLEEP: begin
        if (rel_ok_q && dis_d == cps_pkg::SW_ON) st_d = cps_pkg::ST_NORMAL;
      end
      default: st_d = cps_pkg::ST_NORMAL;
    endcase
  end

  // sleep holds until wake; wake is the external vcc recovery
  logic sleep_q, sleep_d;
  assign sleep_d = (st_q == cps_pkg::ST_UV_WAIT && uv_done && uv_still) ?
                   1'b1 : (wake_i ? 1'b0 : sleep_q); // RULE13 RULE15
  assign sleep_o = sleep_q;

  // switch drive: bits pass through outside protection; the discharge bit also passes during over-charge
  logic in_sleep_st;
  assign in_sleep_st = (st_q == cps_pkg::ST_UV_SLEEP);
  always_comb begin
    chg_d = chg_q;
    dis_d = dis_q;
    rel_ok_d = rel_ok_q;
    case (st_q)
      cps_pkg::ST_OV_PROT: begin
        chg_d = cps_pkg::SW_OFF; // RULE5 RULE8
        dis_d = dis_bit_lvl; // RULE9
        // release edge keeps discharge; stored bits apply a cycle later
        if (&cell_ovr_below_i) begin
          chg_d = cps_pkg::SW_ON; // RULE10
          dis_d = dis_q;
        end
      end
      cps_pkg::ST_UV_SLEEP: begin
        rel_ok_d = rel_ok_q || rel_done;
        if (!sleep_o && ctrl_write_i && ctrl_i.charge_bit) begin
          chg_d = cps_pkg::SW_ON; // RULE15
        end
        if (!sleep_o && rel_ok_q && ctrl_write_i && ctrl_i.discharge_bit) begin
          dis_d = cps_pkg::SW_ON; // RULE15
        end
      end
      default: begin
        rel_ok_d = 1'b0;
        chg_d = chg_bit_lvl;
        dis_d = dis_bit_lvl;
      end
    endcase
    // entering protection: over-charge turns charge off, discharge untouched; over-discharge turns both off
    if (st_q == cps_pkg::ST_OV_WAIT && ov_done && ov_still) begin
      chg_d = cps_pkg::SW_OFF; // RULE5
      dis_d = dis_q; // RULE6
    end
    if (st_q == cps_pkg::ST_UV_WAIT && uv_done && uv_still) begin
      chg_d = cps_pkg::SW_OFF;
      dis_d = cps_pkg::SW_OFF; // RULE13
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= cps_pkg::ST_NORMAL;
      chg_q <= cps_pkg::SW_ON;
      dis_q <= cps_pkg::SW_ON;
      rel_ok_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      st_q <= st_d;
      chg_q <= chg_d;
      dis_q <= dis_d;
      rel_ok_q <= rel_ok_d;
      sleep_q <= sleep_d;
    end
  end

  assign charge_switch_ctrl_o = chg_q;
  assign discharge_switch_ctrl_o = dis_q;
  assign ov_prot_o = (st_q == cps_pkg::ST_OV_PROT);
  assign uv_prot_o = in_sleep_st;

  // sample window gates the voltage checks in normal mode
  window_closed_a: assert property ( // RULE2
    @(posedge clk_i) disable iff (rst_i)
    normal_sel && !sample_en_o && st_q == cps_pkg::ST_NORMAL &&
    !any_set(cell_under_i) |=> st_q != cps_pkg::ST_OV_WAIT)
    else $error("over-charge check outside sample window");
  sample_open_a: assert property ( // RULE2
    @(posedge clk_i) disable iff (rst_i)
    per_wrap |=> sample_en_o && per_q == '0)
    else $error("sample window did not open at period start");

  // monitor mode ignores the sampler; over-current is never gated
  monitor_cont_a: assert property ( // RULE4
    @(posedge clk_i) disable iff (rst_i)
    !normal_sel && st_q == cps_pkg::ST_NORMAL && any_set(cell_over_i) &&
    !any_set(cell_under_i) |=> st_q == cps_pkg::ST_OV_WAIT)
    else $error("monitor mode did not check continuously");
  oc_always_a: assert property ( // RULE3
    @(posedge clk_i) disable iff (rst_i)
    oc_check_en_o)
    else $error("over-current check gated");

  // a seen crossing starts its delay; under-voltage wins a tie
  ov_start_a: assert property ( // RULE7
    @(posedge clk_i) disable iff (rst_i)
    st_q == cps_pkg::ST_NORMAL && ov_seen && !uv_seen |=>
    st_q == cps_pkg::ST_OV_WAIT)
    else $error("over-charge delay did not start");
  uv_start_a: assert property ( // RULE13
    @(posedge clk_i) disable iff (rst_i)
    st_q == cps_pkg::ST_NORMAL && uv_seen |=> st_q == cps_pkg::ST_UV_WAIT)
    else $error("over-discharge delay did not start");

  // over-charge entry: charge off, discharge left alone
  ov_entry_a: assert property ( // RULE5
    @(posedge clk_i) disable iff (rst_i)
    st_q == cps_pkg::ST_OV_WAIT && ov_done && ov_still |=>
    ov_prot_o && charge_switch_ctrl_o == cps_pkg::SW_OFF)
    else $error("over-charge entry failed");
  ov_dis_keep_a: assert property ( // RULE6
    @(posedge clk_i) disable iff (rst_i)
    st_q == cps_pkg::ST_OV_WAIT && ov_done && ov_still |=>
    $stable(discharge_switch_ctrl_o))
    else $error("discharge changed on over-charge entry");
  ov_recheck_a: assert property ( // RULE7
    @(posedge clk_i) disable iff (rst_i)
    st_q == cps_pkg::ST_OV_WAIT && ov_done && !ov_still |=> !ov_prot_o)
    else $error("protection entered without recheck");

  // during protection the charge bit is stored but not shown
  ov_hold_a: assert property ( // RULE8
    @(posedge clk_i) disable iff (rst_i)
    ov_prot_o && $past(ov_prot_o) |->
    charge_switch_ctrl_o == cps_pkg::SW_OFF)
    else $error("charge output leaked during protection");
  bits_store_a: assert property ( // RULE17
    @(posedge clk_i) disable iff (rst_i)
    ctrl_write_i |=> bits_q == $past(ctrl_i))
    else $error("control bits not stored");
  ov_dis_follow_a: assert property ( // RULE9
    @(posedge clk_i) disable iff (rst_i)
    ov_prot_o && $past(ov_prot_o) && $stable(bits_q) |->
    discharge_switch_ctrl_o == dis_bit_lvl)
    else $error("discharge bit not applied during over-charge");

  // release: charge back on, discharge unchanged on that edge
  ov_release_a: assert property ( // RULE10
    @(posedge clk_i) disable iff (rst_i)
    ov_prot_o && &cell_ovr_below_i |=> !ov_prot_o &&
    charge_switch_ctrl_o == cps_pkg::SW_ON &&
    $stable(discharge_switch_ctrl_o))
    else $error("over-charge release failed");

  // over-discharge: both off, asleep until wake, strict recovery order
  uv_entry_a: assert property ( // RULE13
    @(posedge clk_i) disable iff (rst_i)
    st_q == cps_pkg::ST_UV_WAIT && uv_done && uv_still |=>
    sleep_o && discharge_switch_ctrl_o == cps_pkg::SW_OFF)
    else $error("over-discharge entry failed");
  sleep_hold_a: assert property ( // RULE13
    @(posedge clk_i) disable iff (rst_i)
    sleep_o && !wake_i |=> sleep_o)
    else $error("sleep left without wake");
  chg_sleep_a: assert property ( // RULE15
    @(posedge clk_i) disable iff (rst_i)
    uv_prot_o && sleep_o |=> charge_switch_ctrl_o == cps_pkg::SW_OFF)
    else $error("charge switched on while asleep");
  uv_order_a: assert property ( // RULE15
    @(posedge clk_i) disable iff (rst_i)
    uv_prot_o && !rel_ok_q |=> discharge_switch_ctrl_o == cps_pkg::SW_OFF)
    else $error("discharge re-enabled out of order");

  // thresholds move only on a config write
  cfg_load_a: assert property ( // RULE11
    @(posedge clk_i) disable iff (rst_i)
    config_write_cmd_i |=> cfg_o == $past(cfg_i))
    else $error("config write not latched");
  cfg_keep_a: assert property ( // RULE14
    @(posedge clk_i) disable iff (rst_i)
    !config_write_cmd_i |=> $stable(cfg_o))
    else $error("thresholds changed without config write");

  // main scenarios worth seeing at least once
  ov_prot_c: cover property (@(posedge clk_i) disable iff (rst_i)
    ov_prot_o ##1 !ov_prot_o);
  ov_drop_c: cover property (@(posedge clk_i) disable iff (rst_i)
    st_q == cps_pkg::ST_OV_WAIT && ov_done && !ov_still);
  uv_sleep_c: cover property (@(posedge clk_i) disable iff (rst_i)
    sleep_o ##1 !sleep_o);
  uv_return_c: cover property (@(posedge clk_i) disable iff (rst_i)
    uv_prot_o ##1 !uv_prot_o);
  window_c: cover property (@(posedge clk_i) disable iff (rst_i)
    sample_en_o ##1 !sample_en_o);
endmodule // cps_sequencer

// *** hw/cps_pkg.sv ***
package cps_pkg;
  // sample timer figures
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SAMPLE_ON_US = 2_000;
  localparam int unsigned SAMPLE_PERIOD_US = 125_000;
  localparam int unsigned SAMPLE_ON_CYC = SAMPLE_ON_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SAMPLE_PERIOD_CYC =
    SAMPLE_PERIOD_US * (CLK_HZ / 1_000_000);
  // capacitor scaling: detect 10 s/uF, release 70 ms/uF, 0.1 uF part
  localparam int unsigned DET_MS_PER_UF = 10_000;
  localparam int unsigned REL_MS_PER_UF = 70;
  localparam int unsigned CAP_NF = 100;
  localparam int unsigned OV_DET_MS = DET_MS_PER_UF * CAP_NF / 1000;
  localparam int unsigned UV_DET_MS = DET_MS_PER_UF * CAP_NF / 1000;
  localparam int unsigned UV_REL_MS = REL_MS_PER_UF * CAP_NF / 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned DLY_W = 32;
  localparam logic [DLY_W-1:0] OV_DET_CYC = DLY_W'(OV_DET_MS * CYC_PER_MS);
  localparam logic [DLY_W-1:0] UV_DET_CYC = DLY_W'(UV_DET_MS * CYC_PER_MS);
  localparam logic [DLY_W-1:0] UV_REL_CYC = DLY_W'(UV_REL_MS * CYC_PER_MS);
  // switch pin levels: high turns the fet off
  localparam logic SW_OFF = 1'b1;
  localparam logic SW_ON = 1'b0;
  localparam int unsigned NCELL = 4;

  typedef struct packed {
    logic [1:0] ov_thresh;
    logic [1:0] uv_thresh;
  } cps_cfg_s;

  typedef struct packed {
    logic charge_bit;
    logic discharge_bit;
  } cps_ctrl_s;

  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_OV_WAIT = 5'h02,
    ST_OV_PROT = 5'h04,
    ST_UV_WAIT = 5'h08,
    ST_UV_SLEEP = 5'h10
  } cps_state_e;
endpackage

// *** hw/cps_delay_timer.sv ***
`timescale 1ns/1ps
// delay counter: done rises once run has stood high for load cycles
module cps_delay_timer #(
  parameter int unsigned W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [W-1:0] load_i,
  output logic done_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic hit;

  // restart from zero whenever run drops
  assign hit = run_i && (cnt_q >= load_i - W'(1));
  assign cnt_d = !run_i ? '0 : (hit ? cnt_q : cnt_q + W'(1));
  assign done_o = hit;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
endmodule // cps_delay_timer

// *** test/cps_host_model.sv ***
`timescale 1ns/1ps
// host side: one-cycle write pulses, fields held until the next write
module cps_host_model (
  input wire logic clk_i,
  output logic config_write_cmd_o,
  output cps_pkg::cps_cfg_s cfg_o,
  output logic ctrl_write_o,
  output cps_pkg::cps_ctrl_s ctrl_o
);
  // idle with both strobes low and the switches asked on
  initial begin
    config_write_cmd_o = 1'b0;
    cfg_o = '0;
    ctrl_write_o = 1'b0;
    ctrl_o = '{charge_bit: 1'b1, discharge_bit: 1'b1};
  end
  // threshold select fields go out together on one strobe
  task automatic write_cfg(input logic [1:0] ov, input logic [1:0] uv);
    @(posedge clk_i);
    cfg_o <= '{ov_thresh: ov, uv_thresh: uv};
    config_write_cmd_o <= 1'b1;
    @(posedge clk_i);
    config_write_cmd_o <= 1'b0;
  endtask
  // sequencer keeps the recovery order: charge on before discharge on
  task automatic write_ctrl(input logic chg, input logic dis);
    @(posedge clk_i);
    ctrl_o <= '{charge_bit: chg, discharge_bit: dis};
    ctrl_write_o <= 1'b1;
    @(posedge clk_i);
    ctrl_write_o <= 1'b0;
  endtask
endmodule // cps_host_model

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned NC = cps_pkg::NCELL;
  localparam logic [31:0] DLY = 32'h0000_0005;
  localparam logic [NC-1:0] ALL = '1;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] as_sel = 3'h0;
  logic [NC-1:0] over = '0;
  logic [NC-1:0] ovr_below = '1;
  logic [NC-1:0] under = '0;
  logic [NC-1:0] uvr_above = '1;
  logic oc = 1'b0;
  logic wake = 1'b0;
  logic cfg_wr, ctrl_wr, smp, oc_en, chg, dis, ovp, uvp, slp;
  cps_pkg::cps_cfg_s cfg_w, cfg_q;
  cps_pkg::cps_ctrl_s ctrl_w;
  int n_errors = 0;
  int cmp_count = 0;

  always #12.5 clk_i = ~clk_i;

  cps_host_model host (.clk_i(clk_i), .config_write_cmd_o(cfg_wr),
    .cfg_o(cfg_w), .ctrl_write_o(ctrl_wr), .ctrl_o(ctrl_w));
  // short sample period and delays keep the run brief
  cps_sequencer #(.NCELL(NC), .SAMPLE_ON_CYC(4), .SAMPLE_PERIOD_CYC(20))
  dut (.clk_i(clk_i), .rst_i(rst_i), .analog_select_bit2_i(as_sel[2]),
    .analog_select_bit1_i(as_sel[1]), .analog_select_bit0_i(as_sel[0]),
    .cell_over_i(over), .cell_ovr_below_i(ovr_below),
    .cell_under_i(under), .cell_uvr_above_i(uvr_above),
    .over_current_i(oc), .wake_i(wake), .config_write_cmd_i(cfg_wr),
    .cfg_i(cfg_w), .ctrl_write_i(ctrl_wr), .ctrl_i(ctrl_w),
    .ov_det_cyc_i(DLY), .uv_det_cyc_i(DLY), .uv_rel_cyc_i(DLY),
    .use_prog_dly_i(1'b1), .cfg_o(cfg_q), .sample_en_o(smp),
    .oc_check_en_o(oc_en), .charge_switch_ctrl_o(chg),
    .discharge_switch_ctrl_o(dis), .ov_prot_o(ovp), .uv_prot_o(uvp),
    .sleep_o(slp));

  task automatic chk(input string nm, input logic [3:0] e,
                     input logic [3:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = ovp;
      1: pick = slp;
      default: pick = smp;
    endcase
  endfunction
  // bounded wait for a level, then judged
  task automatic wait_sig(input string nm, input int s, input logic l,
                          input int lim);
    int i;
    i = 0;
    // step off the edge so a just-launched output is settled
    #1;
    while (pick(s) !== l && i < lim) begin
      cyc(1);
      i++;
    end
    chk(nm, 4'(l), 4'(pick(s)));
  endtask
  // start of an off phase, so the next window is 16 cycles away
  task automatic align();
    wait_sig("smp", 2, 1'b1, 25);
    wait_sig("smp", 2, 1'b0, 25);
  endtask

  task automatic t_reset();
    chk("chg", 4'(cps_pkg::SW_ON), 4'(chg));
    chk("dis", 4'(cps_pkg::SW_ON), 4'(dis));
    chk("prot", 4'h0, {1'b0, ovp, uvp, slp});
    chk("smp", 4'h1, 4'(smp));
  endtask
  task automatic t_sample();
    int n;
    n = 0;
    align();
    @(posedge clk_i) over <= 4'h2;
    oc <= 1'b1;
    @(posedge clk_i) over <= '0;
    repeat (20) begin
      cyc(1);
      n += int'(smp);
    end
    chk("on cycles", 4'h4, 4'(n));
    chk("ovp", 4'h0, 4'(ovp));
    chk("oc_en", 4'h1, 4'(oc_en));
    @(posedge clk_i) oc <= 1'b0;
  endtask
  task automatic t_monitor();
    @(posedge clk_i) as_sel <= 3'h1;
    align();
    @(posedge clk_i) over <= 4'h1;
    @(posedge clk_i) over <= '0;
    cyc(15);
    chk("ovp", 4'h0, 4'(ovp));
    align();
    @(posedge clk_i) over <= 4'h8;
    ovr_below <= 4'h7;
    wait_sig("ovp", 0, 1'b1, 12);
    @(posedge clk_i) over <= '0;
    ovr_below <= ALL;
    wait_sig("ovp", 0, 1'b0, 25);
    @(posedge clk_i) as_sel <= 3'h0;
  endtask
  task automatic t_ov();
    host.write_ctrl(1'b1, 1'b0);
    cyc(2);
    chk("dis", 4'(cps_pkg::SW_OFF), 4'(dis));
    @(posedge clk_i) over <= 4'h4;
    ovr_below <= 4'hB;
    wait_sig("ovp", 0, 1'b1, 40);
    chk("chg", 4'(cps_pkg::SW_OFF), 4'(chg));
    chk("dis", 4'(cps_pkg::SW_OFF), 4'(dis));
    @(posedge clk_i) over <= '0;
    host.write_ctrl(1'b0, 1'b1);
    cyc(3);
    chk("chg", 4'(cps_pkg::SW_OFF), 4'(chg));
    @(posedge clk_i) ovr_below <= ALL;
    wait_sig("ovp", 0, 1'b0, 25);
    chk("chg", 4'(cps_pkg::SW_ON), 4'(chg));
    cyc(2);
    chk("chg", 4'(cps_pkg::SW_OFF), 4'(chg));
    chk("dis", 4'(cps_pkg::SW_ON), 4'(dis));
    host.write_ctrl(1'b1, 1'b1);
  endtask
  task automatic t_uv();
    @(posedge clk_i) as_sel <= 3'h4;
    under <= 4'h1;
    uvr_above <= 4'hE;
    wait_sig("slp", 1, 1'b1, 40);
    chk("off", 4'h7, {1'b0, uvp, chg, dis});
    @(posedge clk_i) under <= '0;
    host.write_ctrl(1'b1, 1'b1);
    cyc(2);
    chk("chg", 4'(cps_pkg::SW_OFF), 4'(chg));
    @(posedge clk_i) wake <= 1'b1;
    @(posedge clk_i) wake <= 1'b0;
    wait_sig("slp", 1, 1'b0, 5);
    host.write_ctrl(1'b1, 1'b1);
    cyc(2);
    chk("sw", {2'h0, cps_pkg::SW_ON, cps_pkg::SW_OFF},
        {2'h0, chg, dis});
    @(posedge clk_i) uvr_above <= ALL;
    cyc(12);
    host.write_ctrl(1'b1, 1'b1);
    cyc(2);
    chk("dis", 4'(cps_pkg::SW_ON), 4'(dis));
    chk("uvp", 4'h0, 4'(uvp));
    @(posedge clk_i) as_sel <= 3'h0;
  endtask
  task automatic t_cfg();
    for (int i = 0; i < 4; i++) begin
      host.write_cfg(2'(i), 2'(3 - i));
      cyc(1);
      chk("cfg", {2'(i), 2'(3 - i)}, cfg_q);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_sample();
    t_monitor();
    t_ov();
    t_uv();
    t_cfg();
    finish_test();
  end
  // watchdog: whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end
endmodule // tb_top
